// *** design/twm_master_seq.sv ***
`timescale 1ns/1ns
module twm_master_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ACK = 6'b000010,
    ST_STOP = 6'b000100,
    ST_TX = 6'b001000,
    ST_RX = 6'b010000,
    ST_WAIT = 6'b100000
  } twm_state_e;

  twm_state_e state;
  logic [2:0] phase;
  logic [3:0] bit_cnt;
  logic [7:0] shifter;
  logic [7:0] data_buf;
  logic [7:0] rate;
  logic stop_en, ack_en, rcv_en, ack_val, irq_en, port_en;
  logic bf, write_collision_flag, ov, ack_st, stop_det, irq_flag;
  logic scl_rel, sda_rel;
  logic gen_reload, gen_run, ovf;
  logic wr_acc, rd_acc, busy;

  //////////////////////////////////////////////////////////////////
  // apb decode; single-cycle access phase, never an error
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign busy = (state != ST_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  // read data mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        twm_pkg::ADDR_CTRL: prdata <= {24'h000000, port_en, irq_en, ack_val, ack_en,
                                       rcv_en, 1'b0, stop_en, 1'b0};
        twm_pkg::ADDR_STAT: prdata <= {25'h0000000, busy, irq_flag, stop_det, ack_st,
                                       ov, write_collision_flag, bf};
        twm_pkg::ADDR_DATA: prdata <= {24'h000000, data_buf};
        twm_pkg::ADDR_RATE: prdata <= {24'h000000, rate};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // rate reload register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate <= twm_pkg::RATE_RESET;
    end else if (wr_acc && paddr == twm_pkg::ADDR_RATE) begin
      rate <= pwdata[7:0];
    end
  end

  // plain control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_val <= 1'b0;
      irq_en <= 1'b0;
      port_en <= 1'b0;
    end else if (wr_acc && paddr == twm_pkg::ADDR_CTRL) begin
      ack_val <= pwdata[twm_pkg::CTRL_ACKVAL];
      irq_en <= pwdata[twm_pkg::CTRL_IRQEN];
      port_en <= pwdata[twm_pkg::CTRL_PORTEN];
    end
  end

  // interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_flag && irq_en;
    end
  end

  //////////////////////////////////////////////////////////////////
  // rate generator; halts while scl released but still low
  twm_rate_gen u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .reload(gen_reload),
    .run(gen_run),
    .reload_value(rate[6:0]),
    .ovf(ovf)
  );

  logic start_cmd;
  logic ctrl_wr;
  logic data_wr;
  assign ctrl_wr = wr_acc && paddr == twm_pkg::ADDR_CTRL && port_en;
  assign data_wr = wr_acc && paddr == twm_pkg::ADDR_DATA;
  assign start_cmd = !busy && port_en;

  //////////////////////////////////////////////////////////////////
  // sequencer: pins, enables, flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      phase <= 3'h0;
      bit_cnt <= 4'h0;
      shifter <= 8'h00;
      data_buf <= 8'h00;
      stop_en <= 1'b0;
      ack_en <= 1'b0;
      rcv_en <= 1'b0;
      bf <= 1'b0;
      write_collision_flag <= 1'b0;
      ov <= 1'b0;
      ack_st <= 1'b0;
      stop_det <= 1'b0;
      irq_flag <= 1'b0;
      scl_rel <= 1'b1;
      sda_rel <= 1'b1;
      gen_reload <= 1'b0;
      gen_run <= 1'b0;
    end else begin
      gen_reload <= 1'b0;
      // software clears of sticky flags; hardware sets below win
      if (wr_acc && paddr == twm_pkg::ADDR_STAT) begin
        if (pwdata[twm_pkg::STAT_WRITE_COLLISION_FLAG]) write_collision_flag <= 1'b0;
        if (pwdata[twm_pkg::STAT_OV]) ov <= 1'b0;
        if (pwdata[twm_pkg::STAT_IRQ]) irq_flag <= 1'b0;
      end
      if (rd_acc && paddr == twm_pkg::ADDR_DATA && state != ST_TX) begin
        bf <= 1'b0;
      end
      if (!port_en) begin
        stop_det <= 1'b0;
      end
      // buffer write: collision if busy, else start transmit
      if (data_wr) begin
        if (busy) begin
          write_collision_flag <= 1'b1;
        end else begin
          data_buf <= pwdata[7:0];
          shifter <= pwdata[7:0];
          bf <= 1'b1;
          scl_rel <= 1'b0; // first low half starts with scl held low
          state <= ST_TX;
          phase <= 3'h0;
          bit_cnt <= 4'h0;
          gen_reload <= 1'b1;
          gen_run <= 1'b1;
        end
      end
      case (state)
        ST_IDLE: begin
          sda_rel <= 1'b1;
          if (ctrl_wr && start_cmd) begin
            if (pwdata[twm_pkg::CTRL_ACK]) begin
              ack_en <= 1'b1;
              scl_rel <= 1'b0;
              sda_rel <= pwdata[twm_pkg::CTRL_ACKVAL];
              state <= ST_ACK;
              phase <= 3'h0;
              gen_reload <= 1'b1;
              gen_run <= 1'b1;
            end else if (pwdata[twm_pkg::CTRL_STOP]) begin
              stop_en <= 1'b1;
              sda_rel <= 1'b0;
              state <= ST_STOP;
              phase <= 3'h0;
            end else if (pwdata[twm_pkg::CTRL_RCV]) begin
              rcv_en <= 1'b1;
              state <= ST_RX;
              phase <= 3'h0;
              bit_cnt <= 4'h0;
              gen_reload <= 1'b1;
              gen_run <= 1'b1;
            end
          end
        end
        ST_ACK: begin
          case (phase)
            3'h0: if (ovf) begin
              scl_rel <= 1'b1;
              gen_run <= 1'b0;
              phase <= 3'h1;
            end
            3'h1: if (scl_in) begin
              gen_reload <= 1'b1;
              gen_run <= 1'b1;
              phase <= 3'h2;
            end
            3'h2: if (ovf) begin
              scl_rel <= 1'b0;
              ack_en <= 1'b0;
              phase <= 3'h3;
            end
            default: if (ovf) begin
              sda_rel <= 1'b1;
              gen_run <= 1'b0;
              state <= ST_IDLE;
            end
          endcase
        end
        ST_STOP: begin
          case (phase)
            3'h0: if (!sda_in) begin
              gen_reload <= 1'b1;
              gen_run <= 1'b1;
              phase <= 3'h1;
            end
            3'h1: if (ovf) begin
              scl_rel <= 1'b1;
              gen_run <= 1'b0;
              phase <= 3'h2;
            end
            3'h2: if (scl_in) begin
              gen_reload <= 1'b1;
              gen_run <= 1'b1;
              phase <= 3'h3;
            end
            3'h3: if (ovf) begin
              sda_rel <= 1'b1;
              phase <= 3'h4;
            end
            3'h4: if (sda_in && scl_in) begin
              stop_det <= 1'b1;
              gen_reload <= 1'b1;
              phase <= 3'h5;
            end
            default: if (ovf) begin
              stop_en <= 1'b0;
              irq_flag <= 1'b1;
              gen_run <= 1'b0;
              state <= ST_IDLE;
            end
          endcase
        end
        ST_TX, ST_RX: begin
          // phase 0: scl low half, 1: waiting for scl high, 2: high half
          case (phase)
            3'h0: if (ovf) begin
              scl_rel <= 1'b1;
              gen_run <= 1'b0;
              phase <= 3'h1;
            end
            3'h1: if (scl_in) begin
              gen_reload <= 1'b1;
              gen_run <= 1'b1;
              phase <= 3'h2;
              if (state == ST_RX) begin
                shifter <= {shifter[6:0], sda_in};
              end
            end
            default: if (ovf) begin
              scl_rel <= 1'b0;
              phase <= 3'h0;
              bit_cnt <= bit_cnt + 4'h1;
              if (state == ST_TX) begin
                if (bit_cnt == twm_pkg::BITS_PER_BYTE - 4'h1) begin
                  sda_rel <= 1'b1;
                  bf <= 1'b0;
                end else if (bit_cnt == twm_pkg::BITS_WITH_ACK - 4'h1) begin
                  ack_st <= sda_in;
                  irq_flag <= 1'b1;
                  gen_run <= 1'b0;
                  state <= ST_IDLE;
                end else begin
                  sda_rel <= shifter[7];
                  shifter <= {shifter[6:0], 1'b0};
                end
              end else if (bit_cnt == twm_pkg::BITS_PER_BYTE - 4'h1) begin
                rcv_en <= 1'b0;
                data_buf <= shifter;
                bf <= 1'b1;
                irq_flag <= 1'b1;
                gen_run <= 1'b0;
                state <= ST_IDLE;
                if (bf) ov <= 1'b1;
              end
            end
          endcase
        end
        default: state <= ST_IDLE;
      endcase
      // first data bit goes out on the first low half
      if (data_wr && !busy) begin
        sda_rel <= pwdata[7];
        shifter <= {pwdata[6:0], 1'b0};
      end
    end
  end

  // open-drain pins: drive low only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      scl_oe <= !scl_rel;
      sda_oe <= !sda_rel;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end
endmodule

// *** design/twm_rate_gen.sv ***
`timescale 1ns/1ns
// reloadable down counter; holds while halted, pulses ovf on reaching zero
module twm_rate_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reload,
  input wire logic run,
  input wire logic [6:0] reload_value,
  output logic ovf
);
  logic [6:0] count;

  // count down from one below the reload value while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 7'h00;
      ovf <= 1'b0;
    end else if (reload) begin
      count <= (reload_value == 7'h00) ? 7'h00 : reload_value - 7'h01;
      ovf <= 1'b0;
    end else if (run) begin
      if (count == 7'h00) begin
        ovf <= 1'b1;
        count <= (reload_value == 7'h00) ? 7'h00 : reload_value - 7'h01;
      end else begin
        ovf <= 1'b0;
        count <= count - 7'h01;
      end
    end else begin
      ovf <= 1'b0;
    end
  end
endmodule

// *** inc/twm_pkg.sv ***
package twm_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_RATE = 8'h0C;
  // control register fields
  localparam int CTRL_STOP = 1;
  localparam int CTRL_RCV = 3;
  localparam int CTRL_ACK = 4;
  localparam int CTRL_ACKVAL = 5;
  localparam int CTRL_IRQEN = 6;
  localparam int CTRL_PORTEN = 7;
  // status register fields
  localparam int STAT_BF = 0;
  localparam int STAT_WRITE_COLLISION_FLAG = 1;
  localparam int STAT_OV = 2;
  localparam int STAT_ACKST = 3;
  localparam int STAT_STOPD = 4;
  localparam int STAT_IRQ = 5;
  localparam int STAT_BUSY = 6;
  // rate reset value and bit counts per byte
  localparam logic [7:0] RATE_RESET = 8'h05;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BITS_WITH_ACK = 4'h9;
endpackage

// *** tb/tb_twm_master_seq.sv ***
`timescale 1ns/1ns
module tb_twm_master_seq;
  localparam logic [7:0] CT = twm_pkg::ADDR_CTRL;
  localparam logic [7:0] ST = twm_pkg::ADDR_STAT;
  localparam logic [7:0] DT = twm_pkg::ADDR_DATA;
  localparam logic [7:0] RT = twm_pkg::ADDR_RATE;
  localparam logic [31:0] EN = 32'h1 << twm_pkg::CTRL_PORTEN | 32'h1 << twm_pkg::CTRL_IRQEN;
  localparam logic [31:0] ACK = 32'h1 << twm_pkg::CTRL_ACK;
  localparam logic [31:0] AV = 32'h1 << twm_pkg::CTRL_ACKVAL;
  localparam logic [31:0] STP = 32'h1 << twm_pkg::CTRL_STOP;
  localparam logic [31:0] RCV = 32'h1 << twm_pkg::CTRL_RCV;
  localparam logic [31:0] BF = 32'h1 << twm_pkg::STAT_BF;
  localparam logic [31:0] WC = 32'h1 << twm_pkg::STAT_WRITE_COLLISION_FLAG;
  localparam logic [31:0] OV = 32'h1 << twm_pkg::STAT_OV;
  localparam logic [31:0] AS = 32'h1 << twm_pkg::STAT_ACKST;
  localparam logic [31:0] SD = 32'h1 << twm_pkg::STAT_STOPD;
  localparam logic [31:0] IQ = 32'h1 << twm_pkg::STAT_IRQ;
  localparam logic [31:0] BY = 32'h1 << twm_pkg::STAT_BUSY;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, send_byte;
  logic [31:0] pwdata, prdata, rd;
  logic scl_out, scl_oe, sda_out, sda_oe, s_scl_oe, s_sda_oe, scl, sda;
  logic clr, ack_en, send_mode, stretch;
  logic [8:0] wire_sh;
  int n_errors, cmp_count;
  // open-drain lines with pull-ups
  assign scl = !((scl_oe && !scl_out) || s_scl_oe);
  assign sda = !((sda_oe && !sda_out) || s_sda_oe);
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end
  // bits seen on the wire at each scl rise
  always @(posedge scl) wire_sh <= {wire_sh[7:0], sda};
  twm_master_seq i_twm_master_seq (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  twm_slave_model i_twm_slave_model (.pclk(pclk), .clr(clr), .scl(scl), .ack_en(ack_en),
    .send_mode(send_mode), .send_byte(send_byte), .stretch(stretch), .scl_oe(s_scl_oe),
    .sda_oe(s_sda_oe));
  ////////////////////////////////////////
  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for ready
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (pready !== 1'h1) n_errors++;
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'h0, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      apb(ST, 1'h0, 32'h0);
      k++;
    end while (rd[twm_pkg::STAT_BUSY] !== 1'h0 && k < 400);
    if (rd[twm_pkg::STAT_BUSY] !== 1'h0) n_errors++;
  endtask
  task automatic slave_set(input logic a, input logic m, input logic [7:0] v, input logic s);
    @(posedge pclk);
    clr <= 1'h1;
    ack_en <= a;
    send_mode <= m;
    send_byte <= v;
    stretch <= s;
    @(posedge pclk);
    clr <= 1'h0;
  endtask
  task automatic rx(input logic [7:0] v);
    slave_set(1'h1, 1'h1, v, 1'h1);
    apb(CT, 1'h1, EN | RCV);
    wait_idle();
  endtask
  // main sequence
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {clr, ack_en, send_mode, send_byte, stretch} = '1;
    n_errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    rdchk(RT, 32'h7F, 32'(twm_pkg::RATE_RESET));
    rdchk(ST, 32'h7F, 32'h0);
    apb(RT, 1'h1, 32'h83);
    rdchk(RT, 32'h7F, 32'h03);
    apb(CT, 1'h1, EN);
    slave_set(1'h1, 1'h0, 8'h00, 1'h1);
    apb(DT, 1'h1, 32'hA5);
    rdchk(ST, BF | BY, BF | BY);
    apb(DT, 1'h1, 32'h11);
    rdchk(ST, WC, WC);
    wait_idle();
    chk(rd & (BF | AS | IQ), IQ);
    chk({23'h0, wire_sh}, {23'h0, 8'hA5, 1'h0});
    chk({31'h0, irq}, 32'h1);
    rdchk(DT, 32'hFF, 32'hA5);
    apb(ST, 1'h1, WC | OV | IQ);
    rdchk(ST, WC | IQ, 32'h0);
    slave_set(1'h0, 1'h0, 8'h00, 1'h0);
    apb(DT, 1'h1, 32'h3C);
    apb(CT, 1'h1, EN | STP);
    rdchk(CT, STP, 32'h0);
    wait_idle();
    chk(rd & AS, AS);
    rx(8'h96);
    chk(rd & (BF | OV), BF);
    rdchk(CT, RCV, 32'h0);
    rdchk(DT, 32'hFF, 32'h96);
    rdchk(ST, BF, 32'h0);
    rx(8'h5A);
    rx(8'hC3);
    chk(rd & OV, OV);
    for (int v = 0; v < 2; v++) begin
      apb(CT, 1'h1, EN | (v == 1 ? AV : 32'h0));
      apb(CT, 1'h1, EN | ACK | (v == 1 ? AV : 32'h0));
      wait_idle();
      rdchk(CT, ACK, 32'h0);
      chk({31'h0, wire_sh[0]}, 32'(v));
    end
    apb(ST, 1'h1, IQ);
    apb(CT, 1'h1, EN | STP);
    wait_idle();
    chk(rd & (SD | IQ), SD | IQ);
    chk({30'h0, scl, sda}, 32'h3);
    apb(CT, 1'h1, 32'h0);
    rdchk(ST, SD, 32'h0);
    wrap_up();
  end
  // cuts a hang short
  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
endmodule
bind twm_master_seq twm_checker i_twm_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));

// *** tb/twm_checker.sv ***
`timescale 1ns/1ns
// watches the apb side and the two bus lines of the sequencer
module twm_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // completed writes to the control register
  sequence s_ctrl_w;
    psel && penable && pready && pwrite && paddr == twm_pkg::ADDR_CTRL;
  endsequence
  sequence s_ack_w;
    s_ctrl_w ##0 pwdata[twm_pkg::CTRL_ACK] && pwdata[twm_pkg::CTRL_PORTEN];
  endsequence
  sequence s_ack_clock;
    scl_oe ##[1:300] !scl_oe ##[1:300] scl_oe;
  endsequence
  // bus answer and line behaviour
  property p_answer;
    psel && !penable |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_one;
    pready |=> !pready;
  endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_ack_drive;
    s_ack_w ##0 !pwdata[twm_pkg::CTRL_ACKVAL] |-> ##[1:3] scl_oe && sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");
  property p_ack_seq;
    s_ack_w |-> ##[1:3] s_ack_clock;
  endproperty
  a_ack_seq: assert property (p_ack_seq) else $error("ack clock missing");
  property p_stop_start;
    s_ctrl_w ##0 pwdata[twm_pkg::CTRL_STOP] && pwdata[twm_pkg::CTRL_PORTEN]
      && !pwdata[twm_pkg::CTRL_ACK] |-> ##[1:3] sda_oe;
  endproperty
  a_stop_start: assert property (p_stop_start) else $error("stop sda not low");
  property p_stop_end;
    $fell(sda_oe) && scl_in |-> $past(scl_in) && $past(scl_in, 2);
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("sda released early");
  property p_no_start;
    $rose(sda_oe) |-> !scl_in;
  endproperty
  a_no_start: assert property (p_no_start) else $error("sda pulled while scl high");
  property p_stretch;
    !scl_oe && !scl_in |=> !scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("scl pulled while stretched");
  property p_irq_off;
    s_ctrl_w ##0 !pwdata[twm_pkg::CTRL_IRQEN] |-> ##2 !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without enable");
  property p_quiet;
    !pslverr && !scl_out && !sda_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("error or high drive seen");
endmodule

// *** tb/twm_slave_model.sv ***
`timescale 1ns/1ns
// target on the two-wire bus: acks, sends one byte, stretches scl
module twm_slave_model (
  input wire logic pclk,
  input wire logic clr,
  input wire logic scl,
  input wire logic ack_en,
  input wire logic send_mode,
  input wire logic [7:0] send_byte,
  input wire logic stretch,
  output logic scl_oe,
  output logic sda_oe
);
  logic scl_d;
  logic [3:0] cnt;
  logic [2:0] hold;
  // counts scl rises; changes sda only after a fall or on clr
  always_ff @(posedge pclk) begin
    scl_d <= scl;
    if (clr) begin
      cnt <= 4'h0;
      hold <= 3'h0;
      scl_oe <= 1'h0;
      sda_oe <= send_mode && !send_byte[7];
    end else if (!scl_d && scl) begin
      cnt <= cnt + 4'h1;
    end else if (scl_d && !scl) begin
      if (send_mode) begin
        sda_oe <= cnt < 4'h8 && !send_byte[3'h7 - cnt[2:0]];
      end else begin
        sda_oe <= cnt == 4'h8 && ack_en;
      end
      scl_oe <= stretch;
      hold <= 3'h6;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
      scl_oe <= stretch && hold != 3'h1;
    end
  end
endmodule
